/* logic/i2c_master_start_and_brg.sv */
// Start-condition sequencer with collision detection and a shared serial clock baud generator.
// Assumes open-drain bus wiring outside and pin levels synchronous to the clock.
`timescale 1ns/1ps
module i2c_master_start_and_brg #(
  parameter int RELOAD_W    = i2c_start_pkg::RELOAD_W,
  parameter int BURST_EDGES = i2c_start_pkg::BURST_EDGES
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Software controls
  input  wire logic                      startReq,
  input  wire logic                      bufferWrite,
  input  wire logic                      spiMode,
  input  wire logic [RELOAD_W-1:0]       baudReloadReg,
  input  wire logic                      collisionClear,
  // Status
  output logic                           busCollisionFlag,
  output logic                           startDone,
  output logic                           busy,
  // Bus pins
  input  wire i2c_start_pkg::busLines_t  lines,
  output i2c_start_pkg::busDrive_t       drive
);
  import i2c_start_pkg::*;

  startState_t state_q;
  startState_t state_d;
  busDrive_t   drive_q;
  busDrive_t   drive_d;
  logic        flag_q;
  logic        flag_d;
  logic        done_q;
  logic        done_d;
  logic        busy_q;
  logic        busy_d;
  logic        sclLevel_q;
  logic        sclLevel_d;
  logic        brgLoad;
  logic        brgRun;
  logic        brgExpire;
  logic        burstStart;
  logic        burstStep;
  logic        burstLast;
  logic        collision;

  // A high level means released in I2C and a driven one in SPI.
  function automatic busDrive_t sclDrive(input logic level, input logic spi, input busDrive_t cur);
    busDrive_t r;
    r        = cur;
    r.sclOut = spi & level;
    r.sclOe  = spi | ~level;
    return r;
  endfunction

  // The same generator clocks both the start sequence and the data bursts.
  baud_generator #(
    .RELOAD_W (RELOAD_W)
  ) u_baud (
    .clock  (clock),
    .rst    (rst),
    .load   (brgLoad),
    .run    (brgRun),
    .reload (baudReloadReg),
    .expire (brgExpire)
  );

  // Counting the edges of one buffer write lets the burst end without software help.
  burst_counter #(
    .EDGES (BURST_EDGES)
  ) u_burst (
    .clock (clock),
    .rst   (rst),
    .start (burstStart),
    .step  (burstStep),
    .last  (burstLast)
  );

  always_comb begin
    state_d    = state_q;
    drive_d    = drive_q;
    sclLevel_d = sclLevel_q;
    done_d     = 1'b0;
    brgLoad    = 1'b0;
    brgRun     = 1'b0;
    burstStart = 1'b0;
    burstStep  = 1'b0;
    collision  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (startReq && !spiMode) begin
          state_d = ST_CHECK;
          drive_d = DRIVE_IDLE;
        end else if (bufferWrite) begin
          state_d    = ST_BURST;
          brgLoad    = 1'b1;
          burstStart = 1'b1;
          sclLevel_d = 1'b0;
          drive_d    = sclDrive(1'b0, spiMode, drive_q);
        end
      end
      ST_CHECK: begin
        // Sampling here, before any drive, catches a line that someone else already holds low.
        if (!lines.sda || !lines.scl) begin
          collision = 1'b1;
        end else begin
          brgLoad = 1'b1;
          state_d = ST_SDA_WAIT;
        end
      end
      ST_SDA_WAIT: begin
        brgRun = 1'b1;
        if (!lines.scl && lines.sda) begin
          collision = 1'b1;
        end else if (!lines.sda) begin
          // Someone else pulled SDA first; restarting the count keeps our hold time honest.
          brgLoad       = 1'b1;
          brgRun        = 1'b0;
          drive_d.sdaOe = 1'b1;
          state_d       = ST_SCL_WAIT;
        end else if (brgExpire) begin
          // The generator has already reloaded itself for the second count.
          drive_d.sdaOe = 1'b1;
          state_d       = ST_SCL_WAIT;
        end
      end
      ST_SCL_WAIT: begin
        // SCL is deliberately not watched here, as competing starts arbitrate later.
        brgRun = 1'b1;
        if (brgExpire) begin
          drive_d.sclOe = 1'b1;
          sclLevel_d    = 1'b0;
          done_d        = 1'b1;
          state_d       = ST_IDLE;
        end
      end
      ST_BURST: begin
        // Collisions are not watched here, so a slave stretching the clock goes unnoticed.
        brgRun = 1'b1;
        if (brgExpire) begin
          burstStep  = 1'b1;
          sclLevel_d = ~sclLevel_q;
          drive_d    = sclDrive(~sclLevel_q, spiMode, drive_q);
          if (burstLast) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        drive_d = DRIVE_IDLE;
      end
    endcase
    if (collision) begin
      state_d = ST_IDLE;
      drive_d = DRIVE_IDLE;
    end
    // A new collision wins over a clear arriving in the same cycle.
    flag_d = collision | (flag_q & ~collisionClear);
    busy_d = (state_d != ST_IDLE);
  end

  // Every output leaves this register bank, so the pins never see decode glitches.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      drive_q    <= DRIVE_IDLE;
      flag_q     <= 1'b0;
      done_q     <= 1'b0;
      busy_q     <= 1'b0;
      sclLevel_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      drive_q    <= drive_d;
      flag_q     <= flag_d;
      done_q     <= done_d;
      busy_q     <= busy_d;
      sclLevel_q <= sclLevel_d;
    end
  end

  assign busCollisionFlag = flag_q;
  assign startDone        = done_q;
  assign busy             = busy_q;
  assign drive            = drive_q;

  // All checks share the system clock and rest while reset is held.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  begin_collision_a: assert property (
    state_q == ST_CHECK && (!lines.sda || !lines.scl)
      |=> flag_q && state_q == ST_IDLE && !drive_q.sdaOe && !drive_q.sclOe)
    else $error("low line at start begin was not treated as collision");

  early_scl_collision_a: assert property (
    state_q == ST_SDA_WAIT && !lines.scl && lines.sda |=> flag_q && state_q == ST_IDLE)
    else $error("SCL low before SDA asserted was not a collision");

  released_at_begin_a: assert property (
    state_q == ST_CHECK |-> !drive_q.sdaOe && !drive_q.sclOe)
    else $error("start did not begin with both lines released");

  load_on_sda_high_a: assert property (
    state_q == ST_CHECK && lines.sda && lines.scl |-> brgLoad ##1 state_q == ST_SDA_WAIT)
    else $error("baud generator not loaded at start begin");

  early_sda_assert_a: assert property (
    state_q == ST_SDA_WAIT && !lines.sda && lines.scl
      |-> brgLoad ##1 drive_q.sdaOe && state_q == ST_SCL_WAIT)
    else $error("SDA not asserted early after being seen low");

  sda_on_expire_a: assert property (
    state_q == ST_SDA_WAIT && lines.sda && lines.scl && brgExpire
      |=> drive_q.sdaOe && !drive_q.sclOe)
    else $error("SDA not asserted at end of first count");

  scl_wait_quiet_a: assert property (
    state_q == ST_SCL_WAIT |=> !$rose(flag_q))
    else $error("collision reported during second count");

  scl_on_expire_a: assert property (
    state_q == ST_SCL_WAIT && brgExpire |=> drive_q.sclOe && drive_q.sdaOe && startDone ##1 !startDone)
    else $error("SCL not asserted at end of second count");

  buffer_starts_brg_a: assert property (
    state_q == ST_IDLE && bufferWrite && !startReq |-> brgLoad ##1 state_q == ST_BURST ##1 brgRun)
    else $error("buffer write did not start the baud generator");

  idle_hold_a: assert property (
    state_q == ST_IDLE && !startReq && !bufferWrite |=> $stable(drive_q) && !brgRun)
    else $error("lines or generator moved while idle");

  flag_set_wins_a: assert property (
    collision && collisionClear |=> flag_q)
    else $error("collision lost against a simultaneous clear");

  released_after_collision_a: assert property (
    collision ##1 (state_q == ST_IDLE && !startReq && !bufferWrite)[*2]
      |-> !drive_q.sdaOe && !drive_q.sclOe)
    else $error("lines driven after collision reset");

  // Start sequencing checks watch the registered drive, which is what the wired bus sees.
  check_entry_a: assert property (
    state_q == ST_IDLE && startReq && !spiMode
      |=> state_q == ST_CHECK && busy && !drive_q.sdaOe && !drive_q.sclOe)
    else $error("start request did not enter the begin check released");

  check_once_a: assert property (
    state_q == ST_CHECK |=> state_q != ST_CHECK)
    else $error("begin check lasted more than one cycle");

  first_count_released_a: assert property (
    state_q == ST_SDA_WAIT |-> !drive_q.sdaOe && !drive_q.sclOe)
    else $error("a line was driven before the first count ended");

  scl_held_off_a: assert property (
    state_q == ST_SCL_WAIT |-> drive_q.sdaOe && !drive_q.sclOe)
    else $error("SCL driven before the second count ended");

  sda_never_high_a: assert property (
    drive_q.sdaOe |-> !drive_q.sdaOut)
    else $error("SDA driven high instead of pulled low");

  done_not_busy_a: assert property (
    startDone |-> !busy)
    else $error("start reported done while still busy");

  // The collision flag may only come from a start and must stay until cleared.
  flag_from_start_a: assert property (
    $rose(flag_q) |-> $past(state_q) == ST_CHECK || $past(state_q) == ST_SDA_WAIT)
    else $error("collision flag set outside a start condition");

  flag_sticky_a: assert property (
    flag_q && !collisionClear |=> flag_q)
    else $error("collision flag dropped without a clear");

  // Burst checks: the clock moves only at expiries and stops by itself.
  spi_start_ignored_a: assert property (
    state_q == ST_IDLE && startReq && spiMode |=> state_q != ST_CHECK)
    else $error("start condition begun in SPI clocking");

  burst_entry_a: assert property (
    state_q == ST_IDLE && bufferWrite && !(startReq && !spiMode)
      |=> state_q == ST_BURST && drive_q.sclOe)
    else $error("buffer write did not begin a clock burst");

  burst_end_a: assert property (
    state_q == ST_BURST && brgExpire && burstLast |=> state_q == ST_IDLE && !busy)
    else $error("burst did not stop after its last edge");

  burst_toggle_a: assert property (
    state_q == ST_BURST && brgExpire |=> $changed({drive_q.sclOut, drive_q.sclOe}))
    else $error("serial clock did not change at a generator expiry");

  burst_steady_a: assert property (
    state_q == ST_BURST && !brgExpire |=> $stable(drive_q))
    else $error("serial clock changed between generator expiries");

  start_done_c: cover property (state_q == ST_SCL_WAIT ##1 startDone);
  collision_c: cover property (state_q == ST_SDA_WAIT && collision);
  early_sda_c: cover property (state_q == ST_SDA_WAIT && !lines.sda && lines.scl);
  burst_done_c: cover property (state_q == ST_BURST ##1 state_q == ST_IDLE);
  flag_race_c: cover property (collision && collisionClear);

endmodule

/* inc/i2c_start_pkg.sv */
// Shared constants, state codes and pin carriers for the start sequencer and baud generator.
// Assumes a single 40 MHz clock and bus pin levels that are already synchronous to it.
// Operation
// - When a start begins, either bus line already low is a collision.
// - SCL low while SDA still high during the start is a collision.
// - On start collision, abort, set the collision flag, return port to idle.
// - Start begins with both lines released; both lines watched until SDA is driven low.
// - SDA high at start begin loads the baud generator, which counts down.
// - SDA low during first count resets generator and drives SDA low early.
// - SDA high through first count: drive SDA low when the count expires.
// - After SDA falls, reload and count to zero; SCL low then is harmless.
// - When the second count expires, drive SCL low, completing the start.
// - One baud generator serves I2C and SPI master clocking, from reload value.
// - A transmit buffer write starts the baud generator counting automatically.
// - When the operation ends, counting stops and the clock holds its level.
// - The generator reloads twice in each full serial clock period.
// - Serial clock frequency is oscillator over four times (reload plus one).
package i2c_start_pkg;

  localparam int RELOAD_W    = 8;
  localparam int TICK_DIV    = 2;
  localparam int BURST_EDGES = 16;
  localparam int GAP_W       = 12;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_CHECK    = 3'h1,
    ST_SDA_WAIT = 3'h3,
    ST_SCL_WAIT = 3'h2,
    ST_BURST    = 3'h6
  } startState_t;

  typedef struct packed {
    logic sda;
    logic scl;
  } busLines_t;

  typedef struct packed {
    logic sdaOut;
    logic sdaOe;
    logic sclOut;
    logic sclOe;
  } busDrive_t;

  localparam busDrive_t DRIVE_IDLE = 4'h0;

endpackage

/* logic/baud_generator.sv */
// Down-counting baud generator with automatic reload on expiry.
// Assumes the reload value is held steady while the generator runs.
`timescale 1ns/1ps
module baud_generator #(
  parameter int RELOAD_W = i2c_start_pkg::RELOAD_W
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // Control
  input  wire logic                load,
  input  wire logic                run,
  input  wire logic [RELOAD_W-1:0] reload,
  // Event
  output logic                     expire
);
  import i2c_start_pkg::*;

  localparam logic [1:0] PRE_LAST = 2'(TICK_DIV - 1);

  logic [RELOAD_W-1:0] count_q;
  logic [RELOAD_W-1:0] count_d;
  logic [1:0]          pre_q;
  logic [1:0]          pre_d;
  logic                expire_q;
  logic                expire_d;

  // One step every TICK_DIV clocks gives a half period of 2*(reload+1) clocks.
  always_comb begin
    count_d  = count_q;
    pre_d    = pre_q;
    expire_d = 1'b0;
    if (load) begin
      count_d = reload;
      pre_d   = 2'h0;
    end else if (run) begin
      if (pre_q == PRE_LAST) begin
        pre_d = 2'h0;
        if (count_q == '0) begin
          expire_d = 1'b1;
          count_d  = reload;
        end else begin
          count_d = count_q - 1'b1;
        end
      end else begin
        pre_d = pre_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q  <= '0;
      pre_q    <= 2'h0;
      expire_q <= 1'b0;
    end else begin
      count_q  <= count_d;
      pre_q    <= pre_d;
      expire_q <= expire_d;
    end
  end

  assign expire = expire_q;

  logic [GAP_W-1:0] gap_q;
  logic             gapValid_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q      <= '0;
      gapValid_q <= 1'b0;
    end else begin
      gap_q      <= expire_q ? '0 : gap_q + 1'b1;
      gapValid_q <= (load || !run) ? 1'b0 : (expire_q ? 1'b1 : gapValid_q);
    end
  end

  expire_spacing_a: assert property (@(posedge clock) disable iff (rst)
    expire_q && gapValid_q && run && !load |-> gap_q == GAP_W'(2 * (int'(reload) + 1) - 1))
    else $error("baud expiry spacing differs from twice reload plus one");

  hold_when_stopped_a: assert property (@(posedge clock) disable iff (rst)
    !run && !load |=> $stable(count_q) && !expire_q)
    else $error("baud generator moved while stopped");

endmodule

/* logic/burst_counter.sv */
// Counts serial clock edges of one buffer-triggered operation.
// Assumes step pulses come only between start and the flagged last edge.
`timescale 1ns/1ps
module burst_counter #(
  parameter int EDGES = i2c_start_pkg::BURST_EDGES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic step,
  // Status
  output logic      last
);
  localparam int CW = $clog2(EDGES + 1);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          last_q;

  always_comb begin
    count_d = count_q;
    if (start) begin
      count_d = CW'(EDGES - 1);
    end else if (step && count_q != '0) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      last_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      last_q  <= (count_d == '0);
    end
  end

  assign last = last_q;

endmodule

/* verif/i2c_bus_model.sv */
// Bus model for the two lines: pull-ups plus another master that may hold either line low.
// Assumes the design drives its pins through the drive carrier and that the model feeds lines back.
`timescale 1ns/1ps
module i2c_bus_model
  import i2c_start_pkg::*;
(
  // Design side
  input  busDrive_t  drive,
  // Other master
  input  wire logic  holdSdaLow,
  input  wire logic  holdSclLow,
  // Wired levels
  output busLines_t  lines
);
  // A released line is pulled high, so no stale value survives a release.
  assign lines.sda = (drive.sdaOe ? drive.sdaOut : 1'b1) & ~holdSdaLow;
  assign lines.scl = (drive.sclOe ? drive.sclOut : 1'b1) & ~holdSclLow;
endmodule

/* verif/testbench.sv */
// Self-checking bench for the start sequencer and the baud generator.
// Assumes the bus model closes the loop from drive back to lines.
`timescale 1ns/1ps
module testbench;
  import i2c_start_pkg::*;
  logic                clock;
  logic                rst;
  logic                startReq;
  logic                bufferWrite;
  logic                spiMode;
  logic                collisionClear;
  logic                holdSdaLow;
  logic                holdSclLow;
  logic [RELOAD_W-1:0] baudReloadReg;
  logic                busCollisionFlag;
  logic                startDone;
  logic                busy;
  busLines_t           lines;
  busDrive_t           drive;
  logic [3:0]          dv;
  int                  miscompares = 0;
  int                  checked = 0;

  assign dv = drive;

  i2c_master_start_and_brg DUT (
    .clock(clock), .rst(rst), .startReq(startReq), .bufferWrite(bufferWrite),
    .spiMode(spiMode), .baudReloadReg(baudReloadReg), .collisionClear(collisionClear),
    .busCollisionFlag(busCollisionFlag), .startDone(startDone), .busy(busy),
    .lines(lines), .drive(drive));

  i2c_bus_model bus (.drive(drive), .holdSdaLow(holdSdaLow), .holdSclLow(holdSclLow), .lines(lines));

  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Returns just after the taking edge has landed.
  task automatic req(input logic s, input logic b);
    @(negedge clock);
    startReq = s;
    bufferWrite = b;
    @(negedge clock);
    startReq = 0;
    bufferWrite = 0;
  endtask

  task automatic wait_bit(input int idx, input logic val, output int n);
    n = 0;
    while (dv[idx] !== val && n < 2000) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic clear_flag();
    collisionClear = 1;
    @(negedge clock);
    collisionClear = 0;
    @(negedge clock);
    check("flagClear", 0, busCollisionFlag);
  endtask

  task automatic t_start(input int r);
    int n;
    baudReloadReg = RELOAD_W'(r);
    req(1, 0);
    wait_bit(2, 1, n);
    check("sdaDelay", 2 + 2 * (r + 1), n);
    wait_bit(0, 1, n);
    check("sclDelay", 2 * (r + 1), n);
    check("startDone", 1, startDone);
    check("busyEnd", 0, busy);
    @(negedge clock);
    check("doneFall", 0, startDone);
  endtask

  task automatic t_coll_check(input logic onSda);
    holdSdaLow = onSda;
    holdSclLow = ~onSda;
    req(1, 0);
    repeat (2) @(negedge clock);
    check("flagCheck", 1, busCollisionFlag);
    check("busyCheck", 0, busy);
    holdSdaLow = 0;
    holdSclLow = 0;
    repeat (5) @(negedge clock);
    check("idleDrive", 0, dv);
    clear_flag();
  endtask

  task automatic t_coll_wait();
    baudReloadReg = 3;
    req(1, 0);
    repeat (4) @(negedge clock);
    holdSclLow = 1;
    // A clear in the very cycle of the collision must lose.
    collisionClear = 1;
    @(negedge clock);
    collisionClear = 0;
    @(negedge clock);
    check("flagWait", 1, busCollisionFlag);
    check("driveWait", 0, dv);
    check("busyWait", 0, busy);
    holdSclLow = 0;
    clear_flag();
  endtask

  task automatic t_early();
    int n;
    baudReloadReg = 3;
    req(1, 0);
    repeat (4) @(negedge clock);
    holdSdaLow = 1;
    wait_bit(2, 1, n);
    check("earlySda", 1, n);
    holdSdaLow = 0;
    holdSclLow = 1;
    repeat (2) @(negedge clock);
    holdSclLow = 0;
    wait_bit(0, 1, n);
    check("earlyScl", 2 * (3 + 1) + 1, n + 2);
    check("noColl", 0, busCollisionFlag);
  endtask

  task automatic t_burst(input logic spi, input int r);
    int n;
    int b;
    logic v;
    logic v0;
    logic [3:0] last;
    spiMode = spi;
    baudReloadReg = RELOAD_W'(r);
    b = spi ? 1 : 0;
    req(spi, 1);
    @(negedge clock);
    v = dv[b];
    v0 = v;
    for (int k = 0; k < BURST_EDGES; k++) begin
      n = 0;
      while (dv[b] === v && n < 200) begin
        @(negedge clock);
        n++;
      end
      v = dv[b];
      if (k > 0) check("halfPeriod", 2 * (r + 1), n);
    end
    check("endLevel", v0, v);
    repeat (2) @(negedge clock);
    check("burstBusy", 0, busy);
    last = dv;
    repeat (4 * (r + 1) + 3) @(negedge clock);
    check("holdLevel", last, dv);
    if (spi) check("spiOe", 1, dv[0]);
    spiMode = 0;
  endtask

  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end

  initial begin
    rst = 1;
    startReq = 0;
    bufferWrite = 0;
    spiMode = 0;
    collisionClear = 0;
    holdSdaLow = 0;
    holdSclLow = 0;
    baudReloadReg = 8'h03;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 0;
    @(negedge clock);
    check("resetDrive", 0, {busCollisionFlag, busy, startDone, dv});
    t_start(3);
    t_coll_check(0);
    t_coll_check(1);
    t_start(9);
    t_coll_wait();
    t_early();
    t_burst(0, 3);
    t_burst(1, 9);
    end_sim();
  end
endmodule
